/* ssrg_checker.sv */
`default_nettype none
module ssrg_checker (
    input wire logic clk_sys, input wire logic rst_n, // clock, reset
    input wire logic [15:0] ques_status, oper_status, dev_status, // status
    input wire logic [7:0] std_events, // events
    input wire logic errq_not_empty, msg_avail, // queues
    input wire logic [1:0] grp_sel, input wire logic [2:0] part_sel, // select
    input wire logic wr_en, rd_en, // strobes
    input wire logic [15:0] wr_data, rd_data, // data
    input wire logic rd_valid, srq, ist_flag, // flags
    input wire logic [7:0] status_byte // status byte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (rd_en |=> rd_valid) else $error("no read answer");
    a_valid_cause: assert property (rd_valid |-> $past(rd_en)) else $error("stray valid");
    a_msb_zero: assert property (rd_valid |-> !rd_data[15]) else $error("bit 15 set");
    a_data_hold: assert property (!rd_en |=> $stable(rd_data)) else $error("data moved");
    a_filter_rw: assert property (wr_en && grp_sel != 2'h3 && part_sel inside {1, 2, 4}
        ##1 rd_en && !wr_en && $stable(grp_sel) && $stable(part_sel)
        |=> rd_data == ($past(wr_data, 2) & 16'h7FFF)) else $error("filter readback");
    a_mav_high: assert property (msg_avail [*3] |-> status_byte[4]) else $error("mav low");
    a_mav_low: assert property (!msg_avail [*3] |-> !status_byte[4]) else $error("mav hi");
    a_srq_cause: assert property (srq |-> (status_byte | $past(status_byte)) != 8'h00)
        else $error("srq without status");
    a_ist_cause: assert property (ist_flag |-> (status_byte | $past(status_byte)) != 8'h00)
        else $error("ist without status");
    cover property (srq);
    cover property (ist_flag);
    cover property (rd_en && part_sel == 3'h3);
endmodule // ssrg_checker
`default_nettype wire

/* ssrg_defs.vh */
`ifndef SSRG_DEFS_VH
`define SSRG_DEFS_VH
`define SSRG_W 16
`define SSRG_MASK 16'h7FFF
`define SSRG_RST 16'h0000
// part select codes
`define SSRG_P_COND 3'h0
`define SSRG_P_PTR 3'h1
`define SSRG_P_NTR 3'h2
`define SSRG_P_EVT 3'h3
`define SSRG_P_ENA 3'h4
// group select codes
`define SSRG_G_QUES 2'h0
`define SSRG_G_OPER 2'h1
`define SSRG_G_DEV 2'h2
`define SSRG_G_TOP 2'h3
// top-level part codes when group is top
`define SSRG_T_STB 3'h0
`define SSRG_T_SRE 3'h1
`define SSRG_T_PPE 3'h2
`define SSRG_T_ESR 3'h3
`define SSRG_T_ESE 3'h4
// status byte bit positions
`define SSRG_B_DEV 2
`define SSRG_B_ERRQ 2
`define SSRG_B_QUES 3
`define SSRG_B_MAV 4
`define SSRG_B_ESB 5
`define SSRG_B_MSS 6
`define SSRG_B_OPER 7
// device group summary enters this questionable condition bit
`define SSRG_DEV_INTO_QUES 14
`define SSRG_PTR_RST 16'h7FFF
`endif

/* ssrg_group.v */
`include "ssrg_defs.vh"
`default_nettype none
module ssrg_group (
    input wire clk_sys, // system clock
    input wire rst_n, // async reset, active low
    input wire [15:0] cond_in, // live condition sources
    input wire [2:0] part_sel, // part addressed
    input wire wr_en, // host write strobe
    input wire rd_en, // host read strobe
    input wire [15:0] wr_data, // host write data
    output reg [15:0] rd_data, // read value of selected part
    output reg summary // group summary bit
);
    // five parts share one bit index per status source
    reg [15:0] cond;
    reg [15:0] ptr;
    reg [15:0] ntr;
    reg [15:0] evt;
    reg [15:0] ena;
    wire [15:0] cond_now;
    wire [15:0] rise;
    wire [15:0] fall;
    wire [15:0] hits;
    wire [15:0] next_evt;
    wire clr_evt;

    assign cond_now = cond_in & `SSRG_MASK;
    assign rise = cond_now & ~cond & ptr;
    assign fall = ~cond_now & cond & ntr;
    assign hits = rise | fall;
    assign clr_evt = rd_en && (part_sel == `SSRG_P_EVT);
    // set beats clear so a coincident edge survives the read
    assign next_evt = ((clr_evt ? `SSRG_RST : evt) | hits) & `SSRG_MASK;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cond <= `SSRG_RST;
            ptr <= `SSRG_PTR_RST;
            ntr <= `SSRG_RST;
            evt <= `SSRG_RST;
            ena <= `SSRG_RST;
            summary <= 1'b0;
            rd_data <= `SSRG_RST;
        end else begin
            cond <= cond_now;
            evt <= next_evt;
            summary <= |(next_evt & ena);
            if (wr_en && part_sel == `SSRG_P_PTR) begin
                ptr <= wr_data & `SSRG_MASK;
            end
            if (wr_en && part_sel == `SSRG_P_NTR) begin
                ntr <= wr_data & `SSRG_MASK;
            end
            if (wr_en && part_sel == `SSRG_P_ENA) begin
                ena <= wr_data & `SSRG_MASK;
            end
            if (rd_en) begin
                if (part_sel == `SSRG_P_COND) begin
                    rd_data <= cond;
                end else if (part_sel == `SSRG_P_PTR) begin
                    rd_data <= ptr;
                end else if (part_sel == `SSRG_P_NTR) begin
                    rd_data <= ntr;
                end else if (part_sel == `SSRG_P_EVT) begin
                    rd_data <= evt;
                end else if (part_sel == `SSRG_P_ENA) begin
                    rd_data <= ena;
                end else begin
                    rd_data <= `SSRG_RST;
                end
            end
        end
    end
endmodule // ssrg_group
`default_nettype wire

/* ssrg_host.sv */
`default_nettype none
module ssrg_host (
    input wire logic clk_sys, // clock
    input wire logic [15:0] rd_data, // read data
    output logic [1:0] grp_sel, // group
    output logic [2:0] part_sel, // part
    output logic wr_en, // write strobe
    output logic rd_en, // read strobe
    output logic [15:0] wr_data // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {grp_sel, part_sel, wr_en, rd_en, wr_data} = '0;
    end
    // every op starts at a falling edge and sets both strobes once
    task automatic wr(input logic [1:0] g, input logic [2:0] p, input logic [15:0] d);
        {grp_sel, part_sel, wr_data, wr_en, rd_en} = {g, p, d, 2'b10};
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [1:0] g, input logic [2:0] p, output logic [15:0] d);
        {grp_sel, part_sel, wr_data, wr_en, rd_en} = {g, p, ~wr_data, 2'b01};
        @(negedge clk_sys);
        d = rd_data;
    endtask
    task automatic idle(input int n);
        {wr_en, rd_en} = 2'b00;
        repeat (n) @(negedge clk_sys);
    endtask
endmodule // ssrg_host
`default_nettype wire

/* ssrg_top.v */
`include "ssrg_defs.vh"
`default_nettype none
module ssrg_top (
    input wire clk_sys, // system clock
    input wire rst_n, // async reset, active low
    input wire [15:0] ques_status, // questionable hardware status
    input wire [15:0] oper_status, // operation hardware status
    input wire [15:0] dev_status, // device hardware status
    input wire [7:0] std_events, // standard event pulses
    input wire errq_not_empty, // error queue holds an entry
    input wire msg_avail, // output queue holds a message
    input wire [1:0] grp_sel, // group addressed
    input wire [2:0] part_sel, // part addressed
    input wire wr_en, // host write strobe, one cycle
    input wire rd_en, // host read strobe, one cycle
    input wire [15:0] wr_data, // host write data
    output reg [15:0] rd_data, // read data, valid cycle after rd_en
    output reg rd_valid, // read data valid pulse
    output reg srq, // service request pulse
    output reg ist_flag, // parallel-poll flag
    output reg [7:0] status_byte // current status byte
);
    ////////////////////////////////////////////////////////////////
    wire [15:0] g_rd_ques;
    wire [15:0] g_rd_oper;
    wire [15:0] g_rd_dev;
    wire sum_ques;
    wire sum_oper;
    wire sum_dev;
    wire [15:0] ques_cond;
    reg [1:0] grp_q;
    reg [2:0] part_q;
    reg [7:0] sre;
    reg [7:0] ppe;
    reg [7:0] esr;
    reg [7:0] ese;
    wire top_wr;
    wire top_rd;
    wire esr_clr;
    wire [7:0] next_esr;
    wire esb;
    wire [7:0] stb_base;
    wire [7:0] next_stb;
    wire mss;

    function wr_hit;
        input [1:0] g;
        input [1:0] want;
        input en;
        begin
            wr_hit = en && (g == want);
        end
    endfunction

    // device summary drops into the questionable condition
    assign ques_cond = {ques_status[15], sum_dev, ques_status[13:0]};

    ssrg_group u_ques (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cond_in(ques_cond),
        .part_sel(part_sel),
        .wr_en(wr_hit(grp_sel, `SSRG_G_QUES, wr_en)),
        .rd_en(wr_hit(grp_sel, `SSRG_G_QUES, rd_en)),
        .wr_data(wr_data),
        .rd_data(g_rd_ques),
        .summary(sum_ques)
    );

    ssrg_group u_oper (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cond_in(oper_status),
        .part_sel(part_sel),
        .wr_en(wr_hit(grp_sel, `SSRG_G_OPER, wr_en)),
        .rd_en(wr_hit(grp_sel, `SSRG_G_OPER, rd_en)),
        .wr_data(wr_data),
        .rd_data(g_rd_oper),
        .summary(sum_oper)
    );

    ssrg_group u_dev (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cond_in(dev_status),
        .part_sel(part_sel),
        .wr_en(wr_hit(grp_sel, `SSRG_G_DEV, wr_en)),
        .rd_en(wr_hit(grp_sel, `SSRG_G_DEV, rd_en)),
        .wr_data(wr_data),
        .rd_data(g_rd_dev),
        .summary(sum_dev)
    );

    ////////////////////////////////////////////////////////////////
    assign top_wr = wr_hit(grp_sel, `SSRG_G_TOP, wr_en);
    assign top_rd = wr_hit(grp_sel, `SSRG_G_TOP, rd_en);
    assign esr_clr = top_rd && (part_sel == `SSRG_T_ESR);
    // new standard events win over the clearing read
    assign next_esr = (esr_clr ? 8'h00 : esr) | std_events;
    assign esb = |(next_esr & ese);

    // bit 2 carries the error queue alone, bit 6 left for the master summary
    assign stb_base[1:0] = 2'h0;
    assign stb_base[`SSRG_B_ERRQ] = errq_not_empty;
    assign stb_base[`SSRG_B_QUES] = sum_ques;
    assign stb_base[`SSRG_B_MAV] = msg_avail;
    assign stb_base[`SSRG_B_ESB] = esb;
    assign stb_base[`SSRG_B_MSS] = 1'b0;
    assign stb_base[`SSRG_B_OPER] = sum_oper;
    // sre bit 6 masked out of the master summary
    assign mss = |(stb_base & sre & 8'hBF);
    assign next_stb = stb_base | {1'b0, mss, 6'h00};

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sre <= 8'h00;
            ppe <= 8'h00;
            esr <= 8'h00;
            ese <= 8'h00;
            status_byte <= 8'h00;
            srq <= 1'b0;
            ist_flag <= 1'b0;
            grp_q <= 2'h0;
            part_q <= 3'h0;
            rd_valid <= 1'b0;
        end else begin
            esr <= next_esr;
            status_byte <= next_stb;
            // rising enabled status bit raises a one-cycle request
            srq <= |(next_stb & ~status_byte & sre & 8'hBF);
            ist_flag <= |(next_stb & ppe);
            rd_valid <= rd_en;
            if (rd_en) begin
                grp_q <= grp_sel;
                part_q <= part_sel;
            end
            if (top_wr && part_sel == `SSRG_T_SRE) begin
                sre <= wr_data[7:0];
            end
            if (top_wr && part_sel == `SSRG_T_PPE) begin
                ppe <= wr_data[7:0];
            end
            if (top_wr && part_sel == `SSRG_T_ESE) begin
                ese <= wr_data[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // group read data already registered, top parts captured here
    reg [7:0] top_rd_data;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            top_rd_data <= 8'h00;
        end else if (top_rd) begin
            if (part_sel == `SSRG_T_STB) begin
                top_rd_data <= status_byte;
            end else if (part_sel == `SSRG_T_SRE) begin
                top_rd_data <= sre;
            end else if (part_sel == `SSRG_T_PPE) begin
                top_rd_data <= ppe;
            end else if (part_sel == `SSRG_T_ESR) begin
                top_rd_data <= esr;
            end else if (part_sel == `SSRG_T_ESE) begin
                top_rd_data <= ese;
            end else begin
                top_rd_data <= 8'h00;
            end
        end
    end

    always @* begin
        if (grp_q == `SSRG_G_QUES) begin
            rd_data = g_rd_ques;
        end else if (grp_q == `SSRG_G_OPER) begin
            rd_data = g_rd_oper;
        end else if (grp_q == `SSRG_G_DEV) begin
            rd_data = g_rd_dev;
        end else begin
            rd_data = {8'h00, top_rd_data};
        end
    end
endmodule // ssrg_top
`default_nettype wire

/* testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_n = 0, errq_not_empty = 0, msg_avail = 0, srq_seen = 0;
    logic [15:0] ques_status = 0, oper_status = 0, dev_status = 0, rd_data, wr_data, d, a, e;
    logic [15:0] pv, nv;
    logic [7:0] std_events = 0, status_byte;
    logic [1:0] grp_sel;
    logic [2:0] part_sel;
    logic wr_en, rd_en, rd_valid, srq, ist_flag;
    logic [15:0] mf [3][5];
    int bad_count = 0, n_checks = 0, cyc = 0;
    always #10 clk_sys = ~clk_sys;
    ssrg_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ques_status(ques_status),
        .oper_status(oper_status), .dev_status(dev_status), .std_events(std_events),
        .errq_not_empty(errq_not_empty), .msg_avail(msg_avail), .grp_sel(grp_sel),
        .part_sel(part_sel), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .srq(srq), .ist_flag(ist_flag),
        .status_byte(status_byte));
    ssrg_host i_host (.clk_sys(clk_sys), .rd_data(rd_data), .grp_sel(grp_sel),
        .part_sel(part_sel), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data));
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task mrd(input int g, input int p);
        i_host.rd(g[1:0], p[2:0], d);
        chk(d, mf[g][p]);
        if (p == 3) mf[g][3] = 0;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (srq) srq_seen <= 1'b1;
        if (cyc > 3000) begin
            bad_count++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(98));
        foreach (mf[g, p]) mf[g][p] = (p == 1) ? 16'h7FFF : 16'h0000;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1;
        msg_avail = 1;
        for (int g = 0; g < 3; g++) begin
            for (int p = 1; p < 5; p++) mrd(g, p);
            for (int p = 1; p < 5; p++) begin
                e = $urandom;
                i_host.wr(g, p, e);
                if (p != 3) mf[g][p] = e & 16'h7FFF;
                mrd(g, p);
            end
        end
        msg_avail = 0;
        i_host.wr(3, 1, 16'h0080);
        i_host.wr(3, 2, 16'h0080);
        for (int i = 0; i < 6; i++) begin
            a = $urandom & 16'h7FFF;
            e = $urandom;
            pv = $urandom;
            nv = $urandom;
            i_host.wr(1, 1, pv);
            i_host.wr(1, 2, nv);
            i_host.wr(1, 4, e);
            mf[1][1] = pv & 16'h7FFF;
            mf[1][2] = nv & 16'h7FFF;
            mrd(1, 2);
            mf[1][4] = e & 16'h7FFF;
            i_host.idle(3);
            srq_seen = 0;
            oper_status = a;
            mf[1][0] = a;
            mf[1][3] |= a & mf[1][1];
            i_host.idle(4);
            chk(status_byte[7], |(mf[1][3] & mf[1][4]));
            chk(ist_flag, |(mf[1][3] & mf[1][4]));
            chk(srq_seen, |(mf[1][3] & mf[1][4]));
            mrd(1, 0);
            i_host.wr(1, 0, ~a);
            mrd(1, 0);
            oper_status = 0;
            mf[1][0] = 0;
            mf[1][3] |= a & mf[1][2];
            i_host.idle(3);
            i_host.wr(1, 3, 16'hFFFF);
            mrd(1, 3);
            mrd(1, 3);
            i_host.idle(3);
            chk(status_byte[7], 1'b0);
        end
        errq_not_empty = 1;
        std_events = 8'h21;
        i_host.idle(1);
        std_events = 8'h00;
        i_host.idle(2);
        chk(status_byte[2], 1'b1);
        i_host.rd(3, 3, d);
        chk(d, 16'h0021);
        i_host.rd(3, 3, d);
        chk(d, 16'h0000);
        i_host.wr(2, 1, 16'h0001);
        i_host.wr(2, 4, 16'h0001);
        dev_status = 16'h8001;
        i_host.idle(4);
        i_host.rd(0, 0, d);
        chk(d, 16'h4000);
        i_host.idle(1);
        final_report();
    end
endmodule // testbench
bind ssrg_top ssrg_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .ques_status(ques_status),
    .oper_status(oper_status), .dev_status(dev_status), .std_events(std_events),
    .errq_not_empty(errq_not_empty), .msg_avail(msg_avail), .grp_sel(grp_sel),
    .part_sel(part_sel), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .srq(srq), .ist_flag(ist_flag),
    .status_byte(status_byte));
`default_nettype wire
